/* File: design/lamp_pkg.sv */
// Package of constants and types for the repeater lamp display logic.
// Overview of operation
// [RQ1] Mode three: first port lamp lit for good link without cut-off, any speed.
// [RQ2] Mode three: second port lamp shows stretched receive activity, blinks under steady receive.
// [RQ3] Each stretched on-period is followed by an equal off-period before relighting.
// [RQ4] Auto speed blink: third lamp lit at 100, dark at 10, fast blink without link.
// [RQ5] Auto speed blink off: third lamp follows the selected speed, lit for 100.
// [RQ6] Collision and activity lamps are per segment, each through a pulse stretcher.
// [RQ7] Collision lights the segment lamp about 120 us, ignoring collisions meanwhile.
// [RQ8] Activity lights the segment lamp about 4 ms, ignoring activity meanwhile.
// [RQ9] Global fault lamp steady when any port cut off or backup supply faulted.
// [RQ10] Backup supply fault lamp lit when the supply is present and faulted.
// [RQ11] Mode four: first lamp lit for good link, blinks off on receive activity.
// [RQ12] Mode four: second lamp lit for good link while cut off, else dark.
// [RQ13] A configuration bit picks mode three or four for all ports and segments.
// [RQ14] Fast blink comes from one free-running divider with equal on and off phases.
// [RQ15] Backup supply fault lamp dark when no supply or no fault.
package lamp_pkg;
    localparam int CLK_MHZ = 200;
    localparam int RX_STRETCH_US = 20000;
    localparam int RX_STRETCH_CYCLES = RX_STRETCH_US * CLK_MHZ;
    localparam int COL_STRETCH_US = 120;
    localparam int COL_STRETCH_CYCLES = COL_STRETCH_US * CLK_MHZ;
    localparam int ACT_STRETCH_US = 4000;
    localparam int ACT_STRETCH_CYCLES = ACT_STRETCH_US * CLK_MHZ;
    localparam int FAST_BLINK_HALF_US = 50000;
    localparam int FAST_BLINK_HALF_CYCLES = FAST_BLINK_HALF_US * CLK_MHZ;
    localparam int NPORTS_DEFAULT = 8;
    localparam int NSEG_DEFAULT = 2;
    localparam int FIELD_MAX = 8;

    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] PORT_LAMPS_OFFSET = 8'h08;
    localparam logic [7:0] SEG_LAMPS_OFFSET = 8'h0C;
    localparam int CTRL_MODE4_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STAT_GLOBAL_BIT = 0;
    localparam int STAT_SUPPLY_LAMP_BIT = 1;
    localparam int STAT_PRESENT_BIT = 2;
    localparam int STAT_FAULT_BIT = 3;
    localparam int PL_FIRST_POS = 0;
    localparam int PL_SECOND_POS = 8;
    localparam int PL_THIRD_POS = 16;
    localparam int SL_COL_POS = 0;
    localparam int SL_ACT_POS = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ON = 2'b01,
        ST_OFF = 2'b10
    } stretch_state_t;

    typedef struct packed {
        stretch_state_t state;
        logic [31:0] count;
    } stretch_t;

    typedef struct packed {
        logic link_ok;
        logic cut_off;
        logic rx_activity;
        logic speed_100;
    } port_status_t;

    typedef struct packed {
        logic port_lamp_first;
        logic port_lamp_second;
        logic port_lamp_third;
    } port_lamps_t;
endpackage

/* File: design/repeater_lamps.sv */
// Lamp display logic for modes three and four with an AXI4-Lite control slave.
`timescale 1ns/100ps
module repeater_lamps #(
    parameter int NPORTS = lamp_pkg::NPORTS_DEFAULT,
    parameter int NSEG = lamp_pkg::NSEG_DEFAULT,
    parameter int RX_LEN = lamp_pkg::RX_STRETCH_CYCLES,
    parameter int COL_LEN = lamp_pkg::COL_STRETCH_CYCLES,
    parameter int ACT_LEN = lamp_pkg::ACT_STRETCH_CYCLES,
    parameter int BLINK_HALF = lamp_pkg::FAST_BLINK_HALF_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire lamp_pkg::port_status_t [NPORTS-1:0] port_status,
    input wire logic [NSEG-1:0] seg_collision,
    input wire logic [NSEG-1:0] seg_activity,
    input wire logic backup_supply_present,
    input wire logic backup_supply_fault,
    output lamp_pkg::port_lamps_t [NPORTS-1:0] port_lamps,
    output logic [NSEG-1:0] seg_collision_lamp,
    output logic [NSEG-1:0] seg_activity_lamp,
    output logic global_fault_lamp,
    output logic backup_supply_fault_lamp
);
    localparam int NS = NPORTS + 2 * NSEG;
    localparam int COL_BASE = NPORTS;
    localparam int ACT_BASE = NPORTS + NSEG;

    if (NPORTS < 1 || NPORTS > lamp_pkg::FIELD_MAX || NSEG < 1 || NSEG > lamp_pkg::FIELD_MAX) begin : g_bad_size
        $error("port or segment count outside the register fields");
    end
    if (RX_LEN < 1 || COL_LEN < 1 || ACT_LEN < 1 || BLINK_HALF < 1) begin : g_bad_len
        $error("stretch and blink lengths must be at least one cycle");
    end

    function automatic logic [31:0] stretch_len(input int idx);
        if (idx < COL_BASE) begin
            return 32'(RX_LEN);
        end
        if (idx < ACT_BASE) begin
            return 32'(COL_LEN);
        end
        return 32'(ACT_LEN);
    endfunction

    // A trigger is looked at only while idle or in the last dark cycle, so retriggers while lit are dropped.
    // Taking it in the last dark cycle keeps a steady trigger at exactly equal lit and dark halves.
    function automatic lamp_pkg::stretch_t stretch_step(input lamp_pkg::stretch_t cur, input logic trig,
                                                        input logic [31:0] len);
        lamp_pkg::stretch_t nxt;
        nxt = cur;
        case (cur.state)
            lamp_pkg::ST_IDLE: begin
                if (trig) begin
                    nxt.state = lamp_pkg::ST_ON;
                    nxt.count = len - 32'h1;
                end
            end
            lamp_pkg::ST_ON: begin
                if (cur.count == 32'h0) begin
                    nxt.state = lamp_pkg::ST_OFF;
                    nxt.count = len - 32'h1;
                end else begin
                    nxt.count = cur.count - 32'h1;
                end
            end
            lamp_pkg::ST_OFF: begin
                if (cur.count == 32'h0) begin
                    nxt.state = trig ? lamp_pkg::ST_ON : lamp_pkg::ST_IDLE;
                    nxt.count = trig ? len - 32'h1 : cur.count;
                end else begin
                    nxt.count = cur.count - 32'h1;
                end
            end
            default: begin
                nxt.state = lamp_pkg::ST_IDLE;
                nxt.count = 32'h0;
            end
        endcase
        return nxt;
    endfunction

    // Control register and synchronised supply pins.
    logic [1:0] ctrl;
    logic [1:0] supply_meta;
    logic [1:0] supply_sync;
    wire mode4 = ctrl[lamp_pkg::CTRL_MODE4_BIT];
    wire auto_speed_blink = ctrl[lamp_pkg::CTRL_AUTO_BIT];
    wire supply_present = supply_sync[0];
    wire supply_faulted = supply_sync[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            supply_meta <= 2'h0;
            supply_sync <= 2'h0;
        end else begin
            supply_meta <= {backup_supply_fault, backup_supply_present};
            supply_sync <= supply_meta;
        end
    end

    // Shared fast blink divider.
    logic [31:0] blink_count;
    logic fast_phase;
    wire blink_wrap = blink_count == 32'(BLINK_HALF - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_count <= 32'h0;
            fast_phase <= 1'b0;
        end else begin
            blink_count <= blink_wrap ? 32'h0 : blink_count + 32'h1; // RQ14
            fast_phase <= fast_phase ^ blink_wrap; // RQ14
        end
    end

    // Pulse stretchers: receive per port, then collision and activity per segment.
    lamp_pkg::stretch_t str [NS];
    lamp_pkg::stretch_t next_str [NS];
    logic [NS-1:0] trig;
    logic [NS-1:0] lit;

    always_comb begin
        for (int i = 0; i < NPORTS; i++) begin
            trig[i] = port_status[i].rx_activity;
        end
        for (int i = 0; i < NSEG; i++) begin
            trig[COL_BASE+i] = seg_collision[i]; // RQ6
            trig[ACT_BASE+i] = seg_activity[i]; // RQ6
        end
    end

    always_comb begin
        for (int i = 0; i < NS; i++) begin
            next_str[i] = stretch_step(str[i], trig[i], stretch_len(i)); // RQ3 RQ7 RQ8
            lit[i] = str[i].state == lamp_pkg::ST_ON;
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < NS; i++) begin
            if (!aresetn) begin
                str[i] <= '{lamp_pkg::ST_IDLE, 32'h0};
            end else begin
                str[i] <= next_str[i];
            end
        end
    end

    // Lamp decode, one mode for every port and segment.
    lamp_pkg::port_lamps_t [NPORTS-1:0] next_port_lamps;
    logic [NPORTS-1:0] cut_vec;
    wire supply_bad = supply_present & supply_faulted;

    always_comb begin
        for (int i = 0; i < NPORTS; i++) begin
            cut_vec[i] = port_status[i].cut_off;
        end
    end

    wire next_global_fault = (|cut_vec) | supply_bad; // RQ9

    always_comb begin
        for (int i = 0; i < NPORTS; i++) begin
            logic good;
            logic spd;
            good = port_status[i].link_ok & ~port_status[i].cut_off;
            spd = port_status[i].speed_100;
            next_port_lamps[i].port_lamp_first = mode4 ? good & ~lit[i] : good; // RQ1 RQ11 RQ13
            next_port_lamps[i].port_lamp_second = mode4 ? port_status[i].link_ok & port_status[i].cut_off
                                                        : lit[i]; // RQ2 RQ12 RQ13
            if (auto_speed_blink) begin
                next_port_lamps[i].port_lamp_third = port_status[i].link_ok ? spd : fast_phase; // RQ4
            end else begin
                next_port_lamps[i].port_lamp_third = spd; // RQ5
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_lamps <= '0;
            seg_collision_lamp <= '0;
            seg_activity_lamp <= '0;
            global_fault_lamp <= 1'b0;
            backup_supply_fault_lamp <= 1'b0;
        end else begin
            port_lamps <= next_port_lamps;
            seg_collision_lamp <= lit[COL_BASE +: NSEG]; // RQ7
            seg_activity_lamp <= lit[ACT_BASE +: NSEG]; // RQ8
            global_fault_lamp <= next_global_fault; // RQ9
            backup_supply_fault_lamp <= supply_bad; // RQ10 RQ15
        end
    end

    // AXI4-Lite slave; address and data are taken together, one answer outstanding per direction.
    wire wr_go = awvalid & wvalid & ~bvalid;
    wire rd_go = arvalid & ~rvalid;
    wire wr_ctrl = awaddr == lamp_pkg::CTRL_OFFSET;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = ~rvalid;

    logic [31:0] read_word;
    logic read_hit;

    always_comb begin
        read_word = 32'h0;
        read_hit = 1'b1;
        case (araddr)
            lamp_pkg::CTRL_OFFSET: read_word[1:0] = ctrl;
            lamp_pkg::STATUS_OFFSET: begin
                read_word[lamp_pkg::STAT_GLOBAL_BIT] = global_fault_lamp;
                read_word[lamp_pkg::STAT_SUPPLY_LAMP_BIT] = backup_supply_fault_lamp;
                read_word[lamp_pkg::STAT_PRESENT_BIT] = supply_present;
                read_word[lamp_pkg::STAT_FAULT_BIT] = supply_faulted;
            end
            lamp_pkg::PORT_LAMPS_OFFSET: begin
                for (int i = 0; i < NPORTS; i++) begin
                    read_word[lamp_pkg::PL_FIRST_POS+i] = port_lamps[i].port_lamp_first;
                    read_word[lamp_pkg::PL_SECOND_POS+i] = port_lamps[i].port_lamp_second;
                    read_word[lamp_pkg::PL_THIRD_POS+i] = port_lamps[i].port_lamp_third;
                end
            end
            lamp_pkg::SEG_LAMPS_OFFSET: begin
                read_word[lamp_pkg::SL_COL_POS +: NSEG] = seg_collision_lamp;
                read_word[lamp_pkg::SL_ACT_POS +: NSEG] = seg_activity_lamp;
            end
            default: read_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= lamp_pkg::CTRL_RESET;
            bvalid <= 1'b0;
            bresp <= lamp_pkg::RESP_OKAY;
        end else if (wr_go) begin
            if (wr_ctrl && wstrb[0]) begin
                ctrl <= wdata[1:0]; // RQ13
            end
            bvalid <= 1'b1;
            bresp <= wr_ctrl ? lamp_pkg::RESP_OKAY : lamp_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= lamp_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= read_word;
            rresp <= read_hit ? lamp_pkg::RESP_OKAY : lamp_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks on port 0, segment 0 and the global and supply fault lamps.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    wire good0 = port_status[0].link_ok & ~port_status[0].cut_off;

    chk_m3_first_link: assert property (!mode4 |=> port_lamps[0].port_lamp_first == $past(good0)) // RQ1
        else $error("mode three first lamp does not follow good link");
    chk_m3_second_rx: assert property (!mode4 |=> port_lamps[0].port_lamp_second == $past(lit[0])) // RQ2
        else $error("mode three second lamp does not follow stretched receive");
    chk_off_follows_on: assert property (lit[0] && str[0].count == 32'h0 |=>
        str[0].state == lamp_pkg::ST_OFF && str[0].count == 32'(RX_LEN - 1)) // RQ3
        else $error("stretched on-period not followed by equal off-period");
    chk_auto_speed_blink: assert property (auto_speed_blink && !port_status[0].link_ok |=>
        port_lamps[0].port_lamp_third == $past(fast_phase)) // RQ4
        else $error("third lamp not blinking without link");
    chk_fixed_speed: assert property (!auto_speed_blink |=>
        port_lamps[0].port_lamp_third == $past(port_status[0].speed_100)) // RQ5
        else $error("third lamp does not follow selected speed");
    chk_col_ignore: assert property (lit[COL_BASE] && str[COL_BASE].count != 32'h0 |=> lit[COL_BASE]) // RQ7
        else $error("collision stretch cut short");
    chk_act_start: assert property (str[ACT_BASE].state == lamp_pkg::ST_IDLE && seg_activity[0] |=>
        lit[ACT_BASE] && str[ACT_BASE].count == 32'(ACT_LEN - 1) ##1 seg_activity_lamp[0]) // RQ8
        else $error("activity stretch did not start with full length");
    chk_global_fault: assert property (1'b1 |=> global_fault_lamp == $past((|cut_vec) | supply_bad)) // RQ9
        else $error("global fault lamp wrong");
    chk_supply_lamp: assert property (!supply_present || !supply_faulted |=> !backup_supply_fault_lamp) // RQ15
        else $error("supply fault lamp lit without a faulted supply");
    chk_m4_first_blink: assert property (mode4 |=> port_lamps[0].port_lamp_first == $past(good0 & ~lit[0])) // RQ11
        else $error("mode four first lamp wrong");
    chk_m4_second_cut: assert property (mode4 |=> port_lamps[0].port_lamp_second ==
        $past(port_status[0].link_ok & port_status[0].cut_off)) // RQ12
        else $error("mode four second lamp wrong");

    cov_rx_stretch: cover property (lit[0] ##1 str[0].state == lamp_pkg::ST_OFF);
    cov_collision: cover property (seg_collision_lamp[0]);
    cov_mode4_cut: cover property (mode4 && port_lamps[0].port_lamp_second);
    cov_reg_write: cover property (wr_go && wr_ctrl);
endmodule // repeater_lamps

/* File: verif/tb_top.sv */
// Self-checking testbench for the repeater lamp logic in display modes three and four.
`timescale 1ns/100ps
module tb_top;
    localparam int NP = 2;
    localparam int NS = 2;
    localparam int RXL = 8;
    localparam int COLL = 4;
    localparam int ACTL = 6;
    localparam int BH = 3;
    localparam logic [4:0] FAULT_TAB [4] = '{5'h12, 5'h08, 5'h0F, 5'h04};

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic awready;
    logic [7:0] awaddr = 8'h00;
    logic wvalid = 1'b0;
    logic wready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic bvalid;
    logic bready = 1'b0;
    logic [1:0] bresp;
    logic arvalid = 1'b0;
    logic arready;
    logic [7:0] araddr = 8'h00;
    logic rvalid;
    logic rready = 1'b0;
    logic [31:0] rdata;
    logic [1:0] rresp;
    lamp_pkg::port_status_t [NP-1:0] port_status = '0;
    logic [NS-1:0] seg_collision = '0;
    logic [NS-1:0] seg_activity = '0;
    logic backup_supply_present = 1'b0;
    logic backup_supply_fault = 1'b0;
    lamp_pkg::port_lamps_t [NP-1:0] port_lamps;
    logic [NS-1:0] seg_collision_lamp;
    logic [NS-1:0] seg_activity_lamp;
    logic global_fault_lamp;
    logic backup_supply_fault_lamp;
    int fail_count = 0;
    int n_tests = 0;
    logic [1:0] resp;
    logic [31:0] rd;
    wire logic [4:0] watch = {port_lamps[0].port_lamp_third, seg_activity_lamp[0], seg_collision_lamp[0],
        port_lamps[0].port_lamp_second, port_lamps[0].port_lamp_first};

    repeater_lamps #(.NPORTS(NP), .NSEG(NS), .RX_LEN(RXL), .COL_LEN(COLL), .ACT_LEN(ACTL), .BLINK_HALF(BH))
    u_repeater_lamps (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .port_status(port_status),
        .seg_collision(seg_collision), .seg_activity(seg_activity),
        .backup_supply_present(backup_supply_present), .backup_supply_fault(backup_supply_fault),
        .port_lamps(port_lamps), .seg_collision_lamp(seg_collision_lamp), .seg_activity_lamp(seg_activity_lamp),
        .global_fault_lamp(global_fault_lamp), .backup_supply_fault_lamp(backup_supply_fault_lamp));

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Bus tasks are entered just after a rising edge so every change lands by non-blocking assignment.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge aclk);
        while (!(awready === 1'b1 && wready === 1'b1)) begin
            @(posedge aclk);
        end
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        @(posedge aclk);
        while (bvalid !== 1'b1) begin
            @(posedge aclk);
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) begin
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        rready <= 1'b1;
        @(posedge aclk);
        while (rvalid !== 1'b1) begin
            @(posedge aclk);
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic set_ports(input logic l, input logic c, input logic x, input logic s);
        @(posedge aclk);
        for (int p = 0; p < NP; p++) begin
            port_status[p] <= '{l, c, x, s};
        end
        repeat (3) @(negedge aclk);
    endtask

    // Measures a whole run at level v and the following run at the opposite level.
    task automatic run_len(input int sel, input logic v, input int len, input string nm);
        int k;
        int n;
        k = 0;
        n = 0;
        @(negedge aclk);
        while (watch[sel] !== ~v && k < 4 * len + 40) begin
            @(negedge aclk);
            k++;
        end
        while (watch[sel] !== v && k < 8 * len + 80) begin
            @(negedge aclk);
            k++;
        end
        while (watch[sel] === v && n < 4 * len + 8) begin
            n++;
            @(negedge aclk);
        end
        chk({nm, " on run"}, 32'(len), 32'(n));
        n = 0;
        while (watch[sel] === ~v && n < 4 * len + 8) begin
            n++;
            @(negedge aclk);
        end
        chk({nm, " off run"}, 32'(len), 32'(n));
    endtask

    task automatic t_reset();
        @(negedge aclk);
        chk("lamps after reset", 32'h0, 32'({port_lamps, seg_collision_lamp, seg_activity_lamp, global_fault_lamp,
            backup_supply_fault_lamp}));
        @(posedge aclk);
        axi_read(lamp_pkg::CTRL_OFFSET, rd, resp);
        chk("ctrl reset", 32'h0, rd);
    endtask

    task automatic t_static();
        for (int m = 0; m < 2; m++) begin
            @(posedge aclk);
            axi_write(lamp_pkg::CTRL_OFFSET, 32'(m), resp);
            for (int i = 0; i < 8; i++) begin
                set_ports(i[2], i[1], 1'b0, i[0]);
                for (int p = 0; p < NP; p++) begin
                    chk("first lamp", 32'(i[2] & ~i[1]), 32'(port_lamps[p].port_lamp_first));
                    chk("third lamp", 32'(i[0]), 32'(port_lamps[p].port_lamp_third));
                    if (m == 1) begin
                        chk("second lamp", 32'(i[2] & i[1]), 32'(port_lamps[p].port_lamp_second));
                    end else begin
                        chk("second lamp idle", 32'h0, 32'(port_lamps[p].port_lamp_second));
                    end
                end
            end
        end
    endtask

    task automatic t_blinks();
        @(posedge aclk);
        axi_write(lamp_pkg::CTRL_OFFSET, 32'h0, resp);
        set_ports(1'b1, 1'b0, 1'b1, 1'b1);
        run_len(1, 1'b1, RXL, "rx stretch");
        set_ports(1'b1, 1'b0, 1'b0, 1'b1);
        @(posedge aclk);
        axi_write(lamp_pkg::CTRL_OFFSET, 32'h1, resp);
        set_ports(1'b1, 1'b0, 1'b1, 1'b1);
        run_len(0, 1'b0, RXL, "mode four rx blink");
        set_ports(1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge aclk);
        axi_write(lamp_pkg::CTRL_OFFSET, 32'h2, resp);
        run_len(4, 1'b1, BH, "fast blink");
        set_ports(1'b1, 1'b0, 1'b0, 1'b1);
        chk("third lamp 100", 32'h1, 32'(port_lamps[0].port_lamp_third));
        set_ports(1'b1, 1'b0, 1'b0, 1'b0);
        chk("third lamp 10", 32'h0, 32'(port_lamps[1].port_lamp_third));
    endtask

    task automatic t_segments();
        @(posedge aclk);
        seg_collision <= 2'h1;
        run_len(2, 1'b1, COLL, "collision stretch");
        chk("other collision lamp", 32'h0, 32'(seg_collision_lamp[1]));
        @(posedge aclk);
        seg_collision <= 2'h0;
        seg_activity <= 2'h1;
        run_len(3, 1'b1, ACTL, "activity stretch");
        chk("other activity lamp", 32'h0, 32'(seg_activity_lamp[1]));
        @(posedge aclk);
        seg_activity <= 2'h0;
    endtask

    task automatic t_faults();
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            backup_supply_present <= FAULT_TAB[i][3];
            backup_supply_fault <= FAULT_TAB[i][2];
            set_ports(1'b1, FAULT_TAB[i][4], 1'b0, 1'b0);
            repeat (3) @(negedge aclk);
            chk("global fault lamp", 32'(FAULT_TAB[i][1]), 32'(global_fault_lamp));
            chk("supply fault lamp", 32'(FAULT_TAB[i][0]), 32'(backup_supply_fault_lamp));
        end
    endtask

    task automatic t_bus();
        @(posedge aclk);
        axi_write(lamp_pkg::STATUS_OFFSET, 32'h0, resp);
        chk("status write response", 32'(lamp_pkg::RESP_SLVERR), 32'(resp));
        axi_read(8'h10, rd, resp);
        chk("unmapped read response", 32'(lamp_pkg::RESP_SLVERR), 32'(resp));
        chk("unmapped read data", 32'h0, rd);
        axi_write(lamp_pkg::CTRL_OFFSET, 32'h3, resp);
        chk("ctrl write response", 32'(lamp_pkg::RESP_OKAY), 32'(resp));
        axi_read(lamp_pkg::CTRL_OFFSET, rd, resp);
        chk("ctrl readback", 32'h3, rd);
        axi_read(lamp_pkg::STATUS_OFFSET, rd, resp);
        chk("status word", 32'h8, rd);
        axi_read(lamp_pkg::PORT_LAMPS_OFFSET, rd, resp);
        chk("port lamp word", 32'h3, rd);
        axi_read(lamp_pkg::SEG_LAMPS_OFFSET, rd, resp);
        chk("segment lamp word", 32'h0, rd);
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_static();
        t_blinks();
        t_segments();
        t_faults();
        t_bus();
        report_and_stop();
    end

    // The tests need a few hundred cycles; this span of 20000 cycles leaves a wide margin.
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule // tb_top
